/* File: pbc_pkg.sv */
// Package for the basic control and identifier register group.
// Assumes a 16-bit management register port and a 10 MHz system clock.
`default_nettype none
package pbc_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [4:0] BASIC_CONTROL_OFFSET   = 5'h00;
  localparam logic [4:0] IDENTIFIER_HIGH_OFFSET = 5'h02;
  localparam logic [4:0] IDENTIFIER_LOW_OFFSET  = 5'h03;
  localparam logic [4:0] LAST_CLEARED_OFFSET    = 5'h0f;

  // ------------------------------------------------------------
  // Control field positions and reset values
  // ------------------------------------------------------------
  localparam int SOFT_RESET_BIT = 15;
  localparam int LOOPBACK_BIT   = 14;
  localparam int POWER_DOWN_BIT = 11;
  localparam int ISOLATE_BIT    = 10;
  localparam logic [15:0] BASIC_CONTROL_RESET = 16'h0000;

  // ------------------------------------------------------------
  // Identifier fields
  // ------------------------------------------------------------
  localparam int OUI_LOW_MSB   = 15;
  localparam int OUI_LOW_LSB   = 10;
  localparam int MODEL_MSB     = 9;
  localparam int MODEL_LSB     = 5;
  localparam int REVISION_MSB  = 4;
  localparam int REVISION_LSB  = 0;

  // ------------------------------------------------------------
  // Soft reset timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS         = 100;
  localparam int SOFT_RESET_TIME_NS    = 400;
  localparam int SOFT_RESET_CYCLES_INT =
    (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SOFT_RESET_CYCLES = 4'(SOFT_RESET_CYCLES_INT);

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pbc_req_type;

  typedef struct packed {
    logic loopback;
    logic power_down;
    logic isolate;
    logic digital_reset;
  } pbc_mode_type;

endpackage
`default_nettype wire

/* File: pbc_reset_seq.sv */
// Soft reset sequencer: holds the digital reset for a fixed count.
// Assumes a one-cycle start pulse on the system clock.
`timescale 1ns/100ps
`default_nettype none
module pbc_reset_seq
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  // Control
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  typedef struct packed {
    logic [3:0] count;
    logic       busy;
    logic       done;
  } pbc_seq_state_type;

  pbc_seq_state_type state_reg;
  pbc_seq_state_type state_next;

  always_comb
  begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    if (start_i)
    begin
      state_next.busy  = 1'b1;
      state_next.count = pbc_pkg::SOFT_RESET_CYCLES;
    end
    else if (state_reg.busy)
    begin
      if (state_reg.count <= 4'h1)
      begin
        state_next.busy  = 1'b0;
        state_next.count = 4'h0;
        state_next.done  = 1'b1;
      end
      else
      begin
        state_next.count = state_reg.count - 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign busy_o = state_reg.busy;
  assign done_o = state_reg.done;

endmodule
`default_nettype wire

/* File: pbc_regs.sv */
// Basic control and identifier register group of a single-pair PHY.
// Assumes a same-clock management port and an external power-down pin.
//
// Function
// - Writing one to control bit 15 holds the digital logic in reset and returns registers 0x0 to 0xF and interrupt status to defaults.
// - Control bit 14 loops MII transmit data back to receive; zero is normal operation.
// - Control bit 11 or the power-down pin enters power-down and bit 11 reads back that state.
// - Control bit 10 isolates the MAC-side interface; clearing it restores normal mode.
// - The first identifier register is read-only and carries organisation identifier bits 21 to 6.
// - The second identifier register holds identifier bits 5 to 0, model number and revision number.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module pbc_regs
#(
  // Arbitrary identity values
  parameter logic [15:0] OUI_HIGH     = 16'h1234,
  parameter logic [5:0]  OUI_LOW      = 6'h15,
  parameter logic [4:0]  MODEL_NUMBER = 5'h0a,
  parameter logic [4:0]  REVISION     = 5'h03
)
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  // Management register port
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // Power-down pin, asynchronous
  input  wire logic        power_down_pin_i,
  // Mode outputs to the PHY
  output logic             loopback_o,
  output logic             power_down_o,
  output logic             isolate_o,
  output logic             digital_reset_o,
  output logic             clear_status_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0]            pin_sync;
    logic                  soft_reset;
    pbc_pkg::pbc_mode_type mode;
    logic [15:0]           rdata;
    logic                  clear_status;
  } pbc_state_type;

  pbc_state_type      state_reg;
  pbc_state_type      state_next;
  pbc_pkg::pbc_req_type req;
  logic               seq_start;
  logic               seq_busy;
  logic               seq_done;

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction

  // Shared by the soft reset start and the mode write
  function automatic logic ctrl_write(input pbc_pkg::pbc_req_type r);
    ctrl_write = r.wr && hit(r.addr, pbc_pkg::BASIC_CONTROL_OFFSET);
  endfunction

  // One merge serves both the output and the readback, so they never disagree
  function automatic logic power_down_state
  (
    input pbc_pkg::pbc_mode_type m,
    input logic                  pin_request
  );
    power_down_state = m.power_down | pin_request;
  endfunction

  // Reserved control bits read zero
  function automatic logic [15:0] control_word
  (
    input logic                  soft_reset,
    input pbc_pkg::pbc_mode_type m,
    input logic                  pin_request
  );
    control_word                          = 16'h0000;
    control_word[pbc_pkg::SOFT_RESET_BIT] = soft_reset;
    control_word[pbc_pkg::LOOPBACK_BIT]   = m.loopback;
    control_word[pbc_pkg::POWER_DOWN_BIT] = power_down_state(m, pin_request);
    control_word[pbc_pkg::ISOLATE_BIT]    = m.isolate;
  endfunction

  // Identity fields are fixed, so this word never depends on state
  function automatic logic [15:0] identifier_low_word();
    identifier_low_word = 16'h0000;
    identifier_low_word[pbc_pkg::OUI_LOW_MSB:pbc_pkg::OUI_LOW_LSB]   = OUI_LOW;
    identifier_low_word[pbc_pkg::MODEL_MSB:pbc_pkg::MODEL_LSB]       = MODEL_NUMBER;
    identifier_low_word[pbc_pkg::REVISION_MSB:pbc_pkg::REVISION_LSB] = REVISION;
  endfunction

  // ------------------------------------------------------------
  // Request decode and soft reset sequencer
  // ------------------------------------------------------------
  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};
  // A start while busy is dropped; one in the done cycle restarts the count and stretches the reset
  assign seq_start = ctrl_write(req) && req.wdata[pbc_pkg::SOFT_RESET_BIT] &&
                     !seq_busy;

  pbc_reset_seq u_seq
  (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .start_i   (seq_start),
    .busy_o    (seq_busy),
    .done_o    (seq_done)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    state_next              = state_reg;
    state_next.pin_sync     = {state_reg.pin_sync[0], power_down_pin_i};
    state_next.clear_status = 1'b0;
    state_next.rdata        = 16'h0000;
    if (seq_start)
    begin
      // Soft reset returns control to defaults at once
      state_next.soft_reset   = 1'b1;
      state_next.mode         = '0;
      state_next.clear_status = 1'b1;
    end
    else if (seq_done)
    begin
      state_next.soft_reset = 1'b0;
    end
    else if (ctrl_write(req) && !seq_busy)
    begin
      // Writes during soft reset are dropped so defaults stand
      state_next.mode.loopback   = req.wdata[pbc_pkg::LOOPBACK_BIT];
      state_next.mode.power_down = req.wdata[pbc_pkg::POWER_DOWN_BIT];
      state_next.mode.isolate    = req.wdata[pbc_pkg::ISOLATE_BIT];
    end
    state_next.mode.digital_reset = state_next.soft_reset;
    if (req.rd)
    begin
      case (req.addr)
        pbc_pkg::BASIC_CONTROL_OFFSET:
        begin
          // Pin request shows in the same bit
          state_next.rdata = control_word(state_reg.soft_reset, state_reg.mode,
                                          state_reg.pin_sync[1]);
        end
        pbc_pkg::IDENTIFIER_HIGH_OFFSET:
          state_next.rdata = OUI_HIGH;
        pbc_pkg::IDENTIFIER_LOW_OFFSET:
        begin
          state_next.rdata = identifier_low_word();
        end
        default:
          state_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      state_reg      <= '0;
      state_reg.mode <= '0;
    end
    else
      state_reg <= state_next;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign reg_rdata_o     = state_reg.rdata;
  assign loopback_o      = state_reg.mode.loopback;
  assign power_down_o    = power_down_state(state_reg.mode, state_reg.pin_sync[1]);
  assign isolate_o       = state_reg.mode.isolate;
  assign digital_reset_o = state_reg.mode.digital_reset;
  assign clear_status_o  = state_reg.clear_status;

endmodule
`default_nettype wire

/* File: pbc_regs_assertions.sv */
// Checker for the control and identifier register group.
// Assumes binding onto pbc_regs with the same identity parameters.
`timescale 1ns/100ps
`default_nettype none
module pbc_regs_assertions
#(
  parameter logic [15:0] OUI_HIGH     = 16'h1234,
  parameter logic [5:0]  OUI_LOW      = 6'h15,
  parameter logic [4:0]  MODEL_NUMBER = 5'h0a,
  parameter logic [4:0]  REVISION     = 5'h03
)
(
  // Clock, reset and bus
  input wire logic        sys_clk_i,
  input wire logic        srst_i,
  input wire logic [4:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // Pin and modes
  input wire logic        power_down_pin_i,
  input wire logic        loopback_o,
  input wire logic        power_down_o,
  input wire logic        isolate_o,
  input wire logic        digital_reset_o,
  input wire logic        clear_status_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  a_soft_start: assert property (reg_wr_i && reg_addr_i == 5'h00 && reg_wdata_i[15]
    && !digital_reset_o |=> digital_reset_o && clear_status_o && !loopback_o && !isolate_o)
    else $error("soft reset did not start");
  a_soft_end: assert property ($rose(digital_reset_o)
    |-> digital_reset_o[*4] ##[1:2] !digital_reset_o) else $error("soft reset length wrong");
  a_clear_pulse: assert property (clear_status_o |=> !clear_status_o)
    else $error("status clear pulse too long");
  a_mode_write: assert property (reg_wr_i && reg_addr_i == 5'h00 && !reg_wdata_i[15]
    && !digital_reset_o |=> loopback_o == $past(reg_wdata_i[14])
    && isolate_o == $past(reg_wdata_i[10])) else $error("mode bits not taken");
  a_pd_write: assert property (reg_wr_i && reg_addr_i == 5'h00 && reg_wdata_i[11]
    && !reg_wdata_i[15] && !digital_reset_o |=> power_down_o) else $error("power-down not set");
  a_pd_pin: assert property (power_down_pin_i[*4] ##0 !digital_reset_o |-> power_down_o)
    else $error("pin power-down not shown");
  a_id_high: assert property (reg_rd_i && reg_addr_i == 5'h02 |=> reg_rdata_o == OUI_HIGH)
    else $error("first identifier wrong");
  a_id_low: assert property (reg_rd_i && reg_addr_i == 5'h03
    |=> reg_rdata_o == {OUI_LOW, MODEL_NUMBER, REVISION}) else $error("second identifier wrong");
endmodule
bind pbc_regs pbc_regs_assertions #(.OUI_HIGH(OUI_HIGH), .OUI_LOW(OUI_LOW),
  .MODEL_NUMBER(MODEL_NUMBER), .REVISION(REVISION)) chk_u (.sys_clk_i(sys_clk_i),
  .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .power_down_pin_i(power_down_pin_i),
  .loopback_o(loopback_o), .power_down_o(power_down_o), .isolate_o(isolate_o),
  .digital_reset_o(digital_reset_o), .clear_status_o(clear_status_o));
`default_nettype wire

/* File: pbc_regs_tb_top.sv */
// Self-checking bench for the control and identifier register group.
// Assumes pbc_regs with default identity values and a 10 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module pbc_regs_tb_top;
  // Default identity values of the design, arbitrary
  localparam logic [15:0] ID_HI = 16'h1234;
  localparam logic [15:0] ID_LO = {6'h15, 5'h0a, 5'h03};
  logic        sys_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic [4:0]  addr      = 5'h00;
  logic [15:0] wdata     = 16'h0000;
  logic        wr_s      = 1'b0;
  logic        rd_s      = 1'b0;
  logic        pin       = 1'b0;
  logic [15:0] rdata;
  logic        lb, pd, iso, dres, clr;
  int          checks      = 0;
  int          miscompares = 0;
  pbc_regs dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .power_down_pin_i(pin), .loopback_o(lb), .power_down_o(pd), .isolate_o(iso),
    .digital_reset_o(dres), .clear_status_o(clr));
  initial
  begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic conclude;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge sys_clk_i);
    wr_s  <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk_i);
    rd_s <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic t_ident;
    chk({11'h000, lb, pd, iso, dres, clr}, 16'h0000);
    wr(5'h02, 16'hffff);
    wr(5'h03, 16'h0000);
    rdc(5'h02, ID_HI);
    rdc(5'h03, ID_LO);
    rdc(5'h1f, 16'h0000);
  endtask
  task automatic t_modes;
    wr(5'h00, 16'h4c00);
    chk({13'h0000, lb, pd, iso}, 16'h0007);
    rdc(5'h00, 16'h4c00);
    wr(5'h00, 16'h0400);
    chk({13'h0000, lb, pd, iso}, 16'h0001);
    wr(5'h00, 16'h0000);
    chk({13'h0000, lb, pd, iso}, 16'h0000);
  endtask
  task automatic t_soft;
    int n;
    wr(5'h00, 16'h4400);
    wr(5'h00, 16'h8000);
    chk({12'h000, dres, clr, lb, iso}, 16'h000c);
    rdc(5'h00, 16'h8000);
    // Busy period swallows this write
    wr(5'h00, 16'h4000);
    n = 0;
    // Look after each edge so the design's update has landed
    while (dres === 1'b1 && n < 10)
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n == 10)
    begin
      miscompares++;
      conclude();
    end
    // Start edge plus four held cycles: low one edge after the swallowed write
    chk(16'(n), 16'h0001);
    rdc(5'h00, 16'h0000);
    chk({15'h0000, lb}, 16'h0000);
  endtask
  task automatic t_pin;
    @(posedge sys_clk_i);
    pin <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk({15'h0000, pd}, 16'h0001);
    rdc(5'h00, 16'h0800);
    @(posedge sys_clk_i);
    pin <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk({15'h0000, pd}, 16'h0000);
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    #1;
    t_ident();
    t_modes();
    t_soft();
    t_pin();
    conclude();
  end
endmodule
`default_nettype wire
